// File: src/mtarc_defines.vh
`ifndef MTARC_DEFINES_VH
`define MTARC_DEFINES_VH

// register offsets (byte addresses, one word each)
`define MTARC_REG_CTRL      8'h00
`define MTARC_REG_THRESH    8'h04
`define MTARC_REG_BEMIN     8'h08
`define MTARC_REG_APPRETRY  8'h0C
`define MTARC_REG_FAILCNT   8'h10
`define MTARC_REG_STATUS    8'h14
`define MTARC_REG_IRQ_STAT  8'h18
`define MTARC_REG_IRQ_MASK  8'h1C

// reset values
`define MTARC_MODE_RST      2'h0
`define MTARC_THRESH_RST    8'h32
`define MTARC_BEMIN_RST     3'h0
`define MTARC_APPRETRY_RST  8'h00

// irq bit positions
`define MTARC_IRQ_DONE      0
`define MTARC_IRQ_CCAFAIL   1

// transmit status codes
`define MTARC_ST_SUCCESS    8'h00
`define MTARC_ST_NOACK      8'h01
`define MTARC_ST_CCAFAIL    8'h02
`define MTARC_ST_APPACK     8'h21

// retry and exponent limits
`define MTARC_CCA_TRIES     3'h4
`define MTARC_ED_CYCLES     3'h6
`define MTARC_MAC_TRIES     3'h6
`define MTARC_BE_MAX        3'h5

// timing: unit backoff 20 symbols of 16 us = 320 us; app retry gap 1..48 ms
`define MTARC_BACKOFF_NS    320000
`define MTARC_APP_MIN_NS    1000000
`define MTARC_APP_MAX_NS    48000000
`define MTARC_CLK_NS        4

`endif

// File: src/mtarc_top.v
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "mtarc_defines.vh"

module mtarc_top #(
	parameter BACKOFF_CYC = `MTARC_BACKOFF_NS / `MTARC_CLK_NS,
	parameter APP_MIN_CYC = `MTARC_APP_MIN_NS / `MTARC_CLK_NS,
	parameter APP_MAX_CYC = `MTARC_APP_MAX_NS / `MTARC_CLK_NS
)(
	input  wire        sys_clk,       // 250 MHz clock
	input  wire        rst_n,         // sync reset, active low
	input  wire [7:0]  reg_addr,      // register byte address
	input  wire [31:0] reg_wdata,     // write data
	input  wire        reg_wr,        // write strobe
	input  wire        reg_rd,        // read strobe
	output reg  [31:0] reg_rdata,     // read data, cycle after strobe
	output reg         irq,           // level interrupt
	input  wire        tx_req,        // one-cycle frame request
	input  wire        tx_bcast,      // frame is broadcast
	input  wire [7:0]  tx_frame_id,   // frame id, 0 suppresses status
	output reg         tx_busy,       // frame in progress
	output reg         tx_hdr_en,     // add vendor header
	output reg         tx_dup_det,    // duplicate detection on receive
	output reg         tx_ack_req,    // ack request bit in frame
	output reg         cca_start,     // pulse: start energy measure
	input  wire        cca_done,      // energy measure valid
	input  wire [7:0]  cca_energy,    // measured energy, threshold units
	output reg         radio_start,   // pulse: send frame on air
	input  wire        radio_done,    // air transmission finished
	input  wire        ack_seen,      // ack received (level at radio_done)
	input  wire        app_ack_seen,  // app-level ack received
	output reg         st_valid,      // pulse: status available
	output reg  [7:0]  st_code,       // transmit status code
	output reg  [7:0]  st_frame_id    // frame id of status
);

	localparam S_IDLE   = 3'h0;
	localparam S_BACK   = 3'h1;
	localparam S_CCA    = 3'h2;
	localparam S_SEND   = 3'h3;
	localparam S_APPGAP = 3'h4;
	localparam S_DONE   = 3'h5;

	reg [2:0]  state_q;
	reg [1:0]  mode_q;
	reg [7:0]  thr_q;
	reg [7:0]  thr_boot_q;
	reg        booted_q;
	reg [2:0]  bemin_q;
	reg [7:0]  appret_q;
	reg [15:0] failcnt_q;
	reg [1:0]  irqst_q;
	reg [1:0]  irqmask_q;
	reg [15:0] lfsr_q;
	reg [2:0]  be_q;
	reg [2:0]  edcnt_q;
	reg [2:0]  ccatry_q;
	reg [2:0]  mactry_q;
	reg [7:0]  apptry_q;
	reg [31:0] wait_q;
	reg        bcast_q;
	reg [7:0]  fid_q;
	reg [7:0]  code_q;
	reg        done_ev;
	reg        fail_ev;

	wire hdr_on = (mode_q == 2'h0) || (mode_q == 2'h3);
	wire ack_on = (mode_q == 2'h0) || (mode_q == 2'h2);
	wire [7:0] app_lim = hdr_on ? appret_q : 8'h00;
	wire busy_ch = (thr_boot_q != 8'h00) && (cca_energy > thr_boot_q);
	wire [15:0] be_mask = (16'h0001 << be_q) - 16'h0001;
	wire [31:0] app_span = APP_MAX_CYC - APP_MIN_CYC + 1;
	wire wr_ok = reg_wr;

	// random backoff periods, bounded by exponent
	function [31:0] bo_cycles;
		input [15:0] rnd;
		begin
			bo_cycles = rnd * BACKOFF_CYC;
		end
	endfunction

	always @(posedge sys_clk)
	begin
		if (!rst_n)
			lfsr_q <= 16'hACE1;
		else
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	// registers and bus
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			mode_q    <= `MTARC_MODE_RST;
			thr_q     <= `MTARC_THRESH_RST;
			bemin_q   <= `MTARC_BEMIN_RST;
			appret_q  <= `MTARC_APPRETRY_RST;
			irqmask_q <= 2'h0;
			reg_rdata <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ok && reg_addr == `MTARC_REG_CTRL)
				mode_q <= reg_wdata[1:0];
			if (wr_ok && reg_addr == `MTARC_REG_THRESH)
				thr_q <= reg_wdata[7:0];
			if (wr_ok && reg_addr == `MTARC_REG_BEMIN)
				bemin_q <= (reg_wdata[2:0] > `MTARC_BE_MAX) ? `MTARC_BE_MAX : reg_wdata[2:0];
			if (wr_ok && reg_addr == `MTARC_REG_APPRETRY)
				appret_q <= reg_wdata[7:0];
			if (wr_ok && reg_addr == `MTARC_REG_IRQ_MASK)
				irqmask_q <= reg_wdata[1:0];
			reg_rdata <= 32'h0000_0000;
			if (reg_rd)
			begin
				case (reg_addr)
				`MTARC_REG_CTRL:     reg_rdata <= {30'h0, mode_q};
				`MTARC_REG_THRESH:   reg_rdata <= {24'h0, thr_q};
				`MTARC_REG_BEMIN:    reg_rdata <= {29'h0, bemin_q};
				`MTARC_REG_APPRETRY: reg_rdata <= {24'h0, appret_q};
				`MTARC_REG_FAILCNT:  reg_rdata <= {16'h0, failcnt_q};
				`MTARC_REG_STATUS:   reg_rdata <= {8'h0, thr_boot_q, code_q, 5'h0, state_q};
				`MTARC_REG_IRQ_STAT: reg_rdata <= {30'h0, irqst_q};
				`MTARC_REG_IRQ_MASK: reg_rdata <= {30'h0, irqmask_q};
				default:             reg_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// threshold captured once after reset release; zero may take effect live
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			booted_q   <= 1'b0;
			thr_boot_q <= 8'h00;
		end
		else
		begin
			booted_q <= 1'b1;
			if (!booted_q || thr_q == 8'h00)
				thr_boot_q <= thr_q;
		end
	end

	// failure counter: same-cycle software write value is taken plus one increment
	always @(posedge sys_clk)
	begin
		if (!rst_n)
			failcnt_q <= 16'h0000;
		else if (fail_ev)
		begin
			if (wr_ok && reg_addr == `MTARC_REG_FAILCNT)
				failcnt_q <= (reg_wdata[15:0] == 16'hFFFF) ? 16'hFFFF : reg_wdata[15:0] + 16'h0001;
			else if (failcnt_q != 16'hFFFF)
				failcnt_q <= failcnt_q + 16'h0001;
		end
		else if (wr_ok && reg_addr == `MTARC_REG_FAILCNT)
			failcnt_q <= reg_wdata[15:0];
	end

	// sticky interrupt bits, set beats write-one-to-clear
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			irqst_q <= 2'h0;
			irq     <= 1'b0;
		end
		else
		begin
			irqst_q <= (irqst_q & ~((wr_ok && reg_addr == `MTARC_REG_IRQ_STAT) ?
				reg_wdata[1:0] : 2'h0)) | {fail_ev, done_ev};
			irq <= |(irqst_q & irqmask_q);
		end
	end

	// transmit sequencer
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_q     <= S_IDLE;
			be_q        <= 3'h0;
			edcnt_q     <= 3'h0;
			ccatry_q    <= 3'h0;
			mactry_q    <= 3'h0;
			apptry_q    <= 8'h00;
			wait_q      <= 32'h0;
			bcast_q     <= 1'b0;
			fid_q       <= 8'h00;
			code_q      <= 8'h00;
			done_ev     <= 1'b0;
			fail_ev     <= 1'b0;
			tx_busy     <= 1'b0;
			tx_hdr_en   <= 1'b1;
			tx_dup_det  <= 1'b1;
			tx_ack_req  <= 1'b0;
			cca_start   <= 1'b0;
			radio_start <= 1'b0;
			st_valid    <= 1'b0;
			st_code     <= 8'h00;
			st_frame_id <= 8'h00;
		end
		else
		begin
			cca_start   <= 1'b0;
			radio_start <= 1'b0;
			st_valid    <= 1'b0;
			done_ev     <= 1'b0;
			fail_ev     <= 1'b0;
			tx_hdr_en   <= hdr_on;
			tx_dup_det  <= hdr_on;
			case (state_q)
			S_IDLE:
				if (tx_req)
				begin
					bcast_q  <= tx_bcast;
					fid_q    <= tx_frame_id;
					tx_busy  <= 1'b1;
					tx_ack_req <= ack_on && !tx_bcast;
					be_q     <= bemin_q;
					edcnt_q  <= 3'h0;
					ccatry_q <= 3'h0;
					mactry_q <= 3'h0;
					apptry_q <= 8'h00;
					wait_q   <= 32'h0;
					state_q  <= S_BACK;
				end
			S_BACK:
				if (wait_q != 32'h0)
					wait_q <= wait_q - 32'h1;
				else if (thr_boot_q == 8'h00)
				begin
					radio_start <= 1'b1;
					state_q     <= S_SEND;
				end
				else
				begin
					cca_start <= 1'b1;
					state_q   <= S_CCA;
				end
			S_CCA:
				if (cca_done)
				begin
					if (!busy_ch)
					begin
						radio_start <= 1'b1;
						state_q     <= S_SEND;
					end
					else if (edcnt_q + 3'h1 < `MTARC_ED_CYCLES)
					begin
						edcnt_q <= edcnt_q + 3'h1;
						wait_q  <= bo_cycles(lfsr_q & be_mask);
						be_q    <= (be_q < `MTARC_BE_MAX) ? be_q + 3'h1 : be_q;
						state_q <= S_BACK;
					end
					else
					begin
						fail_ev <= 1'b1;
						edcnt_q <= 3'h0;
						be_q    <= bemin_q;
						if (ccatry_q + 3'h1 < `MTARC_CCA_TRIES)
						begin
							ccatry_q <= ccatry_q + 3'h1;
							wait_q   <= 32'h0;
							state_q  <= S_BACK;
						end
						else if (apptry_q < app_lim)
						begin
							apptry_q <= apptry_q + 8'h01;
							ccatry_q <= 3'h0;
							mactry_q <= 3'h0;
							wait_q   <= APP_MIN_CYC + ({16'h0, lfsr_q} % app_span);
							state_q  <= S_APPGAP;
						end
						else
						begin
							code_q  <= `MTARC_ST_CCAFAIL;
							state_q <= S_DONE;
						end
					end
				end
			S_SEND:
				if (radio_done)
				begin
					if (!tx_ack_req || ack_seen)
					begin
						if (app_lim != 8'h00 && !bcast_q && !app_ack_seen && apptry_q < app_lim)
						begin
							apptry_q <= apptry_q + 8'h01;
							mactry_q <= 3'h0;
							ccatry_q <= 3'h0;
							wait_q   <= APP_MIN_CYC;
							state_q  <= S_APPGAP;
						end
						else
						begin
							code_q  <= (app_lim != 8'h00 && !bcast_q && !app_ack_seen) ?
								`MTARC_ST_APPACK : `MTARC_ST_SUCCESS;
							state_q <= S_DONE;
						end
					end
					else if (mactry_q + 3'h1 < `MTARC_MAC_TRIES)
					begin
						mactry_q <= mactry_q + 3'h1;
						be_q     <= bemin_q;
						edcnt_q  <= 3'h0;
						wait_q   <= 32'h0;
						state_q  <= S_BACK;
					end
					else if (apptry_q < app_lim)
					begin
						apptry_q <= apptry_q + 8'h01;
						mactry_q <= 3'h0;
						ccatry_q <= 3'h0;
						wait_q   <= APP_MIN_CYC;
						state_q  <= S_APPGAP;
					end
					else
					begin
						code_q  <= (app_lim != 8'h00) ? `MTARC_ST_APPACK : `MTARC_ST_NOACK;
						state_q <= S_DONE;
					end
				end
			S_APPGAP:
				if (wait_q != 32'h0)
					wait_q <= wait_q - 32'h1;
				else
				begin
					be_q    <= bemin_q;
					edcnt_q <= 3'h0;
					state_q <= S_BACK;
				end
			S_DONE:
			begin
				tx_busy     <= 1'b0;
				done_ev     <= 1'b1;
				st_valid    <= (fid_q != 8'h00);
				st_code     <= code_q;
				st_frame_id <= fid_q;
				state_q     <= S_IDLE;
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

endmodule

// File: verification/mtarc_chk.sv
`timescale 1ns/1ps
module mtarc_chk (
	input wire logic        sys_clk,     // clock
	input wire logic        rst_n,       // sync reset
	input wire logic [7:0]  reg_addr,    // reg address
	input wire logic [31:0] reg_wdata,   // write data
	input wire logic        reg_wr,      // write strobe
	input wire logic        reg_rd,      // read strobe
	input wire logic [31:0] reg_rdata,   // read data
	input wire logic        tx_req,      // frame request
	input wire logic        tx_bcast,    // broadcast
	input wire logic        tx_busy,     // frame active
	input wire logic        tx_hdr_en,   // header on
	input wire logic        tx_dup_det,  // dup detect
	input wire logic        tx_ack_req,  // ack request
	input wire logic        cca_start,   // measure pulse
	input wire logic        cca_done,    // measure done
	input wire logic [7:0]  cca_energy,  // energy
	input wire logic        radio_start, // send pulse
	input wire logic        radio_done,  // send done
	input wire logic        st_valid     // status pulse
);
	logic [1:0] mode_q;
	logic       thr_off_q;
	logic       bc_q;
	// boot threshold stays at reset value; only a zero write changes it
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			mode_q <= 2'h0;
			thr_off_q <= 1'b0;
			bc_q <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == 8'h00)
				mode_q <= reg_wdata[1:0];
			if (reg_wr && reg_addr == 8'h04 && reg_wdata[7:0] == 8'h00)
				thr_off_q <= 1'b1;
			if (tx_req && !tx_busy)
				bc_q <= tx_bcast;
		end
	end
	sequence s_acc;
		tx_req && !tx_busy && !thr_off_q;
	endsequence
	sequence s_clear;
		cca_done && cca_energy <= 8'h32;
	endsequence
	sequence s_busy;
		cca_done && cca_energy > 8'h32 && !thr_off_q;
	endsequence
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	hdr_dup_a: assert property (tx_dup_det == tx_hdr_en)
		else $error("dup detect differs from header");
	hdr_mode_a: assert property (radio_start |-> tx_hdr_en == (mode_q == 2'h0 || mode_q == 2'h3))
		else $error("header flag wrong for mode");
	ack_req_a: assert property (radio_start |-> tx_ack_req == (!bc_q && !mode_q[0]))
		else $error("ack request wrong");
	first_cca_a: assert property (s_acc |-> ##2 cca_start)
		else $error("first check delayed");
	busy_hold_a: assert property (s_busy |=> !radio_start)
		else $error("sent on busy channel");
	clear_go_a: assert property (s_clear |=> radio_start)
		else $error("clear channel not used");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	st_gap_a: assert property (st_valid |-> $past(radio_done, 2) || $past(cca_done, 2))
		else $error("status at wrong time");
endmodule
bind mtarc_top mtarc_chk u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .tx_req, .tx_bcast, .tx_busy, .tx_hdr_en, .tx_dup_det, .tx_ack_req,
	.cca_start, .cca_done, .cca_energy, .radio_start, .radio_done, .st_valid);

// File: verification/mtarc_radio.sv
`timescale 1ns/1ps
module mtarc_radio (
	input  wire logic       sys_clk,     // clock
	input  wire logic       rst_n,       // sync reset
	input  wire logic       clr,         // new frame
	input  wire logic [7:0] lat,         // answer delay
	input  wire logic [7:0] busy_n,      // busy checks first
	input  wire logic [7:0] nack_n,      // sends unacked first
	input  wire logic [7:0] clr_lvl,     // clear energy
	input  wire logic       app_ok,      // app ack given
	input  wire logic       cca_start,   // measure req
	input  wire logic       radio_start, // send req
	input  wire logic       tx_ack_req,  // ack asked
	output logic            cca_done,    // measure done
	output logic [7:0]      cca_energy,  // energy
	output logic            radio_done,  // send done
	output logic            ack_seen,    // ack back
	output logic            app_ack_seen // app ack back
);
	logic [7:0] ccas_q, sends_q, cnt_q;
	logic       cca_p_q, tx_p_q;
	always @(posedge sys_clk)
	begin
		cca_done <= 1'b0;
		radio_done <= 1'b0;
		// idle lines carry junk so stale values are never trusted
		cca_energy <= ~cca_energy;
		ack_seen <= ~ack_seen;
		app_ack_seen <= ~app_ack_seen;
		if (!rst_n)
		begin
			{cca_energy, ack_seen, app_ack_seen} <= 10'h0;
			{cca_p_q, tx_p_q, cnt_q} <= 10'h0;
		end
		else if (cca_start || radio_start)
		begin
			cca_p_q <= cca_start;
			tx_p_q <= radio_start;
			cnt_q <= lat;
		end
		else if (cnt_q != 8'h0)
			cnt_q <= cnt_q - 8'h1;
		else if (cca_p_q)
		begin
			cca_p_q <= 1'b0;
			cca_done <= 1'b1;
			cca_energy <= (ccas_q < busy_n) ? 8'hFF : clr_lvl;
			ccas_q <= ccas_q + 8'h1;
		end
		else if (tx_p_q)
		begin
			tx_p_q <= 1'b0;
			radio_done <= 1'b1;
			ack_seen <= tx_ack_req && sends_q >= nack_n;
			app_ack_seen <= app_ok;
			sends_q <= sends_q + 8'h1;
		end
		if (clr || !rst_n)
		begin
			ccas_q <= 8'h0;
			sends_q <= 8'h0;
		end
	end
endmodule

// File: verification/tb_mac_tx_access_retry_control.sv
`timescale 1ns/1ps
`include "mtarc_defines.vh"
module tb_mac_tx_access_retry_control;
	logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h0, tx_frame_id = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'h6C20B106;
	logic        tx_req = 1'b0, tx_bcast = 1'b0, app_ok = 1'b1, irq, tx_busy;
	logic        id_zero = 1'b0;
	logic        tx_hdr_en, tx_dup_det, tx_ack_req, cca_start, cca_done;
	logic        radio_start, radio_done, ack_seen, app_ack_seen, st_valid;
	logic [7:0]  cca_energy, st_code, st_frame_id;
	logic [7:0]  lat = 8'h0, busy_n = 8'h0, nack_n = 8'h0, clr_lvl = 8'h20;
	int          err_count = 0, tests_run = 0, cyc = 0, n_rs = 0, n_cca = 0;
	mtarc_top #(.BACKOFF_CYC(4), .APP_MIN_CYC(10), .APP_MAX_CYC(40)) dut (.sys_clk, .rst_n,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .tx_req, .tx_bcast,
		.tx_frame_id, .tx_busy, .tx_hdr_en, .tx_dup_det, .tx_ack_req, .cca_start, .cca_done,
		.cca_energy, .radio_start, .radio_done, .ack_seen, .app_ack_seen, .st_valid,
		.st_code, .st_frame_id);
	mtarc_radio u_rad (.sys_clk, .rst_n, .clr(tx_req), .lat, .busy_n, .nack_n, .clr_lvl,
		.app_ok, .cca_start, .radio_start, .tx_ack_req, .cca_done, .cca_energy,
		.radio_done, .ack_seen, .app_ack_seen);
	always #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// header and duplicate detection belong to modes 0 and 3
	function automatic logic hdr_exp(input int m);
		return (m == 0) || (m == 3);
	endfunction
	task conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (radio_start === 1'b1)
			n_rs++;
		if (cca_start === 1'b1)
			n_cca++;
		if (cyc == 60000)
		begin
			err_count++;
			conclude;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata & m, e);
	endtask
	task frame(input logic bc, input logic [7:0] code);
		logic [7:0] id;
		int t;
		lfsr = nxt(lfsr);
		id = id_zero ? 8'h00 : (lfsr[7:0] | 8'h01);
		n_rs = 0;
		n_cca = 0;
		@(posedge sys_clk);
		tx_req <= 1'b1;
		tx_bcast <= bc;
		tx_frame_id <= id;
		lat <= {5'h0, lfsr[10:8]};
		@(posedge sys_clk);
		tx_req <= 1'b0;
		t = 0;
		// busy drops with the status slot, so a zero id still ends the wait
		while (st_valid !== 1'b1 && !(t > 0 && tx_busy === 1'b0) && t < 20000)
		begin
			@(negedge sys_clk);
			t++;
		end
		chk(32'(st_valid), 32'(!id_zero));
		chk(32'(tx_busy), 32'h0);
		chk({24'h0, st_code}, {24'h0, code});
		chk({24'h0, st_frame_id}, {24'h0, id});
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'h00, 32'h3, 32'h0);
		rd(8'h04, 32'hFF, 32'h32);
		rd(8'h08, 32'h7, 32'h0);
		rd(8'h10, 32'hFFFF, 32'h0);
		rd(8'h20, 32'hFFFFFFFF, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h00, 32'(m));
			repeat (2) @(posedge sys_clk);
			chk(32'(tx_hdr_en), 32'(hdr_exp(m)));
			chk(32'(tx_dup_det), 32'(hdr_exp(m)));
			frame(1'b0, `MTARC_ST_SUCCESS);
			frame(1'b1, `MTARC_ST_SUCCESS);
		end
		wr(8'h00, 32'h0);
		nack_n = 8'd6;
		frame(1'b0, `MTARC_ST_NOACK);
		chk(n_rs, 6);
		nack_n = 8'd5;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(n_rs, 6);
		wr(8'h0C, 32'h1);
		nack_n = 8'd0;
		app_ok = 1'b0;
		frame(1'b0, `MTARC_ST_APPACK);
		app_ok = 1'b1;
		frame(1'b0, `MTARC_ST_SUCCESS);
		wr(8'h0C, 32'h0);
		wr(8'h00, 32'h1);
		nack_n = 8'd6;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(n_rs, 1);
		wr(8'h08, 32'h3);
		busy_n = 8'd5;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(n_cca, 6);
		busy_n = 8'd0;
		clr_lvl = 8'h32;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(n_cca, 1);
		clr_lvl = 8'h20;
		wr(8'h1C, 32'h2);
		wr(8'h10, 32'hFFFE);
		busy_n = 8'd6;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(32'(irq), 32'h1);
		rd(8'h10, 32'hFFFF, 32'hFFFF);
		busy_n = 8'd24;
		frame(1'b0, `MTARC_ST_CCAFAIL);
		chk(n_cca, 24);
		rd(8'h10, 32'hFFFF, 32'hFFFF);
		rd(8'h18, 32'h2, 32'h2);
		wr(8'h18, 32'h2);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), 32'h0);
		wr(8'h1C, 32'h0);
		wr(8'h10, 32'h0);
		busy_n = 8'd6;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(32'(irq), 32'h0);
		rd(8'h10, 32'hFFFF, 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h0C, 32'h1);
		busy_n = 8'd48;
		frame(1'b0, `MTARC_ST_CCAFAIL);
		chk(n_cca, 48);
		rd(8'h10, 32'hFFFF, 32'h9);
		wr(8'h0C, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h10);
		rd(8'h14, 32'hFF0000, 32'h320000);
		wr(8'h04, 32'h0);
		busy_n = 8'd99;
		id_zero = 1'b1;
		frame(1'b0, `MTARC_ST_SUCCESS);
		chk(n_cca, 0);
		conclude;
	end
endmodule
